/* File: design/fdr_regs.sv */
// serial-port register bank: boost, timing, thermistor, flags, id
`timescale 1ns/1ps
`include "fdr_map.svh"
module fdr_regs
  import fdr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h30,
  // identity values are arbitrary
  parameter logic [2:0] PART_ID = 3'h5,
  parameter logic [2:0] SILICON_REV = 3'h1,
  parameter bit HIGH_TORCH = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic [1:0] i_operating_mode_field,
  input wire logic [7:0] i_fault_primary,
  input wire logic [4:0] i_fault_secondary,
  input wire logic i_flash_monitor_valid,
  input wire logic [6:0] i_flash_monitor_code,
  output logic o_soft_reset,
  output logic o_device_enabled,
  output logic o_short_detect_en,
  output logic o_pass_mode_only,
  output logic o_freq_4mhz,
  output logic o_ilim_high,
  output logic [10:0] o_flash_timeout_ms,
  output logic [10:0] o_torch_ramp_ms,
  output logic o_torch_active_low,
  output logic o_torch_pulldown_en,
  output logic o_thermistor_open_en,
  output logic o_thermistor_short_en,
  output logic [2:0] o_temperature_threshold,
  output logic o_torch_pin_function
);
  // ==========================================
  // signals
  fdr_i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic sda_low_reg;
  logic is_read_reg;
  logic first_reg;
  logic nack_reg;
  logic scl_q;
  logic sda_q;
  logic [3:0] boost_reg;
  logic [6:0] timing_reg;
  logic [6:0] therm_reg;
  logic [6:0] last_flash_reg;
  logic soft_reset_reg;
  logic enabled_reg;
  logic [7:0] fault_pri;
  logic [4:0] fault_sec;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_end;
  logic addr_hit;
  logic wr_fire;
  logic ptr_fire;
  logic ld_fire;
  logic sw_reset_hit;
  logic dev_enabled;
  fdr_op_mode_t op_mode;

  // ==========================================
  // bus line edges
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  assign scl_rise = i_scl && !scl_q;
  assign scl_fall = !i_scl && scl_q;
  assign start_det = i_scl && scl_q && sda_q && !i_sda;
  assign stop_det = i_scl && scl_q && !sda_q && i_sda;
  assign byte_end = scl_fall && (bit_cnt_reg == 4'h8);
  assign addr_hit = (shift_reg[7:1] == DEV_ADDR);
  assign wr_fire = (state_reg == ST_WR) && byte_end && !first_reg;
  assign ptr_fire = (state_reg == ST_WR) && byte_end && first_reg;
  assign ld_fire = scl_fall
                   && (((state_reg == ST_ACK_ADDR) && is_read_reg)
                   || ((state_reg == ST_ACK_RD) && !nack_reg));

  // ==========================================
  // serial protocol state
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      is_read_reg <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      first_reg <= 1'b1;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          bit_cnt_reg <= 4'h0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            if (addr_hit) begin
              state_reg <= ST_ACK_ADDR;
              is_read_reg <= shift_reg[0];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= is_read_reg ? ST_RD : ST_WR;
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            state_reg <= ST_ACK_WR;
          end
        end
        ST_ACK_WR: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            first_reg <= 1'b0;
            state_reg <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            state_reg <= ST_ACK_RD;
          end
        end
        ST_ACK_RD: begin
          if (scl_rise) begin
            nack_reg <= i_sda;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= nack_reg ? ST_IDLE : ST_RD;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // receive shifter and register pointer
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_reg <= 8'h00;
    end else if (scl_rise
                 && (state_reg == ST_ADDR || state_reg == ST_WR)) begin
      shift_reg <= {shift_reg[6:0], i_sda};
    end
  end

  // pointer advances after every written data byte and as each read byte is loaded for sending
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_reg <= 8'h00;
    end else if (ptr_fire) begin
      ptr_reg <= shift_reg;
    end else if (wr_fire || ld_fire) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // ==========================================
  // data line drive
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_reg <= 8'h00;
      sda_low_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_low_reg <= 1'b0;
    end else if (ld_fire) begin
      tx_reg <= rd_data;
      sda_low_reg <= !rd_data[7];
    end else if (byte_end) begin
      if (state_reg == ST_ADDR) begin
        sda_low_reg <= addr_hit;
      end else if (state_reg == ST_WR) begin
        sda_low_reg <= 1'b1;
      end else begin
        sda_low_reg <= 1'b0;
      end
    end else if (scl_fall && state_reg == ST_RD) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
      sda_low_reg <= !tx_reg[6];
    end else if (scl_fall) begin
      sda_low_reg <= 1'b0;
    end
  end

  assign o_sda = 1'b0;
  assign o_sda_oe_n = !sda_low_reg;

  // ==========================================
  // mode decode
  assign op_mode = fdr_op_mode_t'(i_operating_mode_field);
  assign dev_enabled = (op_mode != FDR_MODE_STANDBY); // RL11

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enabled_reg <= 1'b0;
    end else begin
      enabled_reg <= dev_enabled; // RL11
    end
  end

  // ==========================================
  // writable registers
  assign sw_reset_hit = wr_fire && (ptr_reg == `FDR_OFS_BOOST)
                        && shift_reg[`FDR_BOOST_SWRST]; // RL1

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boost_reg <= 4'(`FDR_BOOST_RST);
    end else if (sw_reset_hit) begin
      boost_reg <= 4'(`FDR_BOOST_RST); // RL12
    end else if (wr_fire && ptr_reg == `FDR_OFS_BOOST) begin
      boost_reg <= shift_reg[3:0]; // RL2
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timing_reg <= 7'(`FDR_TIMING_RST);
    end else if (sw_reset_hit) begin
      timing_reg <= 7'(`FDR_TIMING_RST); // RL12
    end else if (wr_fire && ptr_reg == `FDR_OFS_TIMING) begin
      timing_reg <= shift_reg[6:0];
    end
  end

  // polarity ignores host writes while any mode other than standby is selected
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      therm_reg <= 7'(`FDR_THERM_RST);
    end else if (sw_reset_hit) begin
      therm_reg <= 7'(`FDR_THERM_RST); // RL12
    end else if (wr_fire && ptr_reg == `FDR_OFS_THERM) begin
      therm_reg[5:0] <= shift_reg[5:0];
      if (!dev_enabled) begin
        therm_reg[`FDR_THERM_POL] <= shift_reg[`FDR_THERM_POL]; // RL7
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= sw_reset_hit; // RL1
    end
  end

  // ==========================================
  // status registers
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_flash_reg <= `FDR_LAST_FLASH_RST;
    end else if (i_flash_monitor_valid) begin
      last_flash_reg <= i_flash_monitor_code; // RL10
    end
  end

  fdr_flag_latch #(
    .W(8)
  ) u_fault_pri (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_event(i_fault_primary), // RL8
    .i_enable({1'b1, {3{boost_reg[`FDR_BOOST_SHORT_EN]}}, 4'hF}), // RL2
    .i_clear(ld_fire && ptr_reg == `FDR_OFS_FAULT_PRI),
    .o_flags(fault_pri)
  );

  fdr_flag_latch #(
    .W(5)
  ) u_fault_sec (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_event(i_fault_secondary), // RL9
    .i_enable({therm_reg[`FDR_THERM_SHORT_EN],
               therm_reg[`FDR_THERM_OPEN_EN], 3'h7}),
    .i_clear(ld_fire && ptr_reg == `FDR_OFS_FAULT_SEC),
    .o_flags(fault_sec)
  );

  // ==========================================
  // read data; unmapped offsets read zero
  always_comb begin
    if (ptr_reg == `FDR_OFS_BOOST) begin
      rd_data = {4'h0, boost_reg}; // RL1
    end else if (ptr_reg == `FDR_OFS_TIMING) begin
      rd_data = {1'b0, timing_reg};
    end else if (ptr_reg == `FDR_OFS_THERM) begin
      rd_data = {1'b0, therm_reg};
    end else if (ptr_reg == `FDR_OFS_FAULT_PRI) begin
      rd_data = fault_pri; // RL8
    end else if (ptr_reg == `FDR_OFS_FAULT_SEC) begin
      rd_data = {3'h0, fault_sec}; // RL9
    end else if (ptr_reg == `FDR_OFS_DEV_ID) begin
      rd_data = {2'h0, PART_ID, SILICON_REV}; // RL13
    end else if (ptr_reg == `FDR_OFS_LAST_FLASH) begin
      rd_data = {1'b0, last_flash_reg}; // RL10
    end else begin
      rd_data = 8'h00;
    end
  end

  // ==========================================
  // timing decode and configuration outputs
  fdr_timing_decode #(
    .HIGH_TORCH(HIGH_TORCH)
  ) u_timing (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_timeout_code(timing_reg[3:0]), // RL6
    .i_ramp_code(timing_reg[6:4]),
    .o_timeout_ms(o_flash_timeout_ms),
    .o_ramp_ms(o_torch_ramp_ms)
  );

  assign o_soft_reset = soft_reset_reg;
  assign o_device_enabled = enabled_reg;
  assign o_short_detect_en = boost_reg[`FDR_BOOST_SHORT_EN]; // RL2
  assign o_pass_mode_only = boost_reg[`FDR_BOOST_PASS]; // RL3
  assign o_freq_4mhz = boost_reg[`FDR_BOOST_FREQ]; // RL4
  assign o_ilim_high = boost_reg[`FDR_BOOST_ILIM]; // RL5
  assign o_torch_active_low = therm_reg[`FDR_THERM_POL]; // RL7
  assign o_torch_pulldown_en = !therm_reg[`FDR_THERM_POL]; // RL7
  assign o_thermistor_open_en = therm_reg[`FDR_THERM_OPEN_EN];
  assign o_thermistor_short_en = therm_reg[`FDR_THERM_SHORT_EN];
  assign o_temperature_threshold = therm_reg[3:1];
  assign o_torch_pin_function = therm_reg[`FDR_THERM_FUNC];
endmodule : fdr_regs

/* File: design/fdr_map.svh */
// register offsets, field positions, reset values and timing figures
// How it works
// RL1: writing 1 to boost bit 7 asks for a software reset; it reads 0.
// RL2: boost bit 3 enables LED short fault detection, on by default.
// RL3: boost bit 2 set limits the converter to pass mode, else normal boost.
// RL4: boost bit 1 picks 2MHz when 0 (default) and 4MHz when 1.
// RL5: boost bit 0 picks 1.9A when 0 and 2.8A when 1 (default).
// RL6: timeout 10..100ms by 10, 150..400ms by 50, default 150, x4 high torch.
// RL7: thermistor bit 6 sets torch polarity, frozen while enabled; a software reset still clears it to 0.
// RL8: primary faults 7..0: tx, out/LED1/LED2 short, ilim, hot, uv, timeout.
// RL9: secondary faults 4..0: short, open, monitor, overvolt, hot; 7:5 read 0.
// RL10: last flash holds the latest 7-bit monitor current code.
// RL11: mode 00 standby, 01 IR, 10 torch, 11 flash; non-standby is enabled.
// RL12: a software reset returns writable registers to defaults.
// RL13: flag, identification and last flash registers ignore host writes.
`ifndef FDR_MAP_SVH
`define FDR_MAP_SVH
// ==========================================
// offsets
`define FDR_OFS_BOOST 8'h07
`define FDR_OFS_TIMING 8'h08
`define FDR_OFS_THERM 8'h09
`define FDR_OFS_FAULT_PRI 8'h0A
`define FDR_OFS_FAULT_SEC 8'h0B
`define FDR_OFS_DEV_ID 8'h0C
`define FDR_OFS_LAST_FLASH 8'h0D
// ==========================================
// fields
`define FDR_BOOST_SWRST 7
`define FDR_BOOST_SHORT_EN 3
`define FDR_BOOST_PASS 2
`define FDR_BOOST_FREQ 1
`define FDR_BOOST_ILIM 0
`define FDR_THERM_POL 6
`define FDR_THERM_OPEN_EN 5
`define FDR_THERM_SHORT_EN 4
`define FDR_THERM_FUNC 0
// ==========================================
// reset values
`define FDR_BOOST_RST 8'h09
`define FDR_TIMING_RST 8'h1A
`define FDR_THERM_RST 8'h08
`define FDR_LAST_FLASH_RST 7'h00
// ==========================================
// timing figures in ms
`define FDR_TMO_FINE_CODES 4'hA
`define FDR_TMO_FINE_STEP_MS 11'h00A
`define FDR_TMO_COARSE_BASE_MS 11'h096
`define FDR_TMO_COARSE_STEP_MS 11'h032
`define FDR_TMO_HIGH_SCALE 11'h004
`define FDR_RAMP_FIRST_MS 11'h001
`define FDR_RAMP_SECOND_MS 11'h020
`endif

/* File: design/fdr_pkg.sv */
// types shared by the flash driver register bank
package fdr_pkg;
  typedef enum logic [1:0] {
    FDR_MODE_STANDBY,
    FDR_MODE_IR,
    FDR_MODE_TORCH,
    FDR_MODE_FLASH
  } fdr_op_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR,
    ST_ACK_WR,
    ST_RD,
    ST_ACK_RD
  } fdr_i2c_state_t;
endpackage : fdr_pkg

/* File: design/fdr_flag_latch.sv */
// sticky fault flags, cleared when the host reads them
`timescale 1ns/1ps
module fdr_flag_latch #(
  parameter int W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_event,
  input wire logic [W-1:0] i_enable,
  input wire logic i_clear,
  output logic [W-1:0] o_flags
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      // a new enabled event wins over a clear in the same cycle
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          o_flags[g] <= 1'b0;
        end else if (i_event[g] && i_enable[g]) begin
          o_flags[g] <= 1'b1;
        end else if (i_clear) begin
          o_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : fdr_flag_latch

/* File: design/fdr_timing_decode.sv */
// turns timeout and ramp codes into durations in ms
`timescale 1ns/1ps
`include "fdr_map.svh"
module fdr_timing_decode #(
  parameter bit HIGH_TORCH = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_timeout_code,
  input wire logic [2:0] i_ramp_code,
  output logic [10:0] o_timeout_ms,
  output logic [10:0] o_ramp_ms
);
  logic [10:0] tmo_next;
  logic [10:0] ramp_next;

  always_comb begin
    if (i_timeout_code < `FDR_TMO_FINE_CODES) begin
      tmo_next = 11'((11'(i_timeout_code) + 11'h001)
                 * `FDR_TMO_FINE_STEP_MS); // RL6
    end else begin
      tmo_next = 11'(`FDR_TMO_COARSE_BASE_MS
                 + 11'(i_timeout_code - `FDR_TMO_FINE_CODES)
                 * `FDR_TMO_COARSE_STEP_MS); // RL6
    end
    if (HIGH_TORCH) begin
      tmo_next = 11'(tmo_next * `FDR_TMO_HIGH_SCALE); // RL6
    end
  end

  always_comb begin
    case (i_ramp_code)
      3'h0: ramp_next = 11'h000;
      3'h1: ramp_next = `FDR_RAMP_FIRST_MS;
      default: ramp_next = 11'(`FDR_RAMP_SECOND_MS << (i_ramp_code - 3'h2));
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_timeout_ms <= 11'h000;
      o_ramp_ms <= 11'h000;
    end else begin
      o_timeout_ms <= tmo_next;
      o_ramp_ms <= ramp_next;
    end
  end
endmodule : fdr_timing_decode

/* File: bench/fdr_regs_props.sv */
// concurrent checks on the ports of the flash driver register bank
`timescale 1ns/1ps
module fdr_regs_props #(
  parameter bit HIGH_TORCH = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic o_sda_oe_n,
  input wire logic [1:0] i_operating_mode_field,
  input wire logic o_soft_reset,
  input wire logic o_device_enabled,
  input wire logic o_short_detect_en,
  input wire logic o_pass_mode_only,
  input wire logic o_freq_4mhz,
  input wire logic o_ilim_high,
  input wire logic [10:0] o_flash_timeout_ms,
  input wire logic [10:0] o_torch_ramp_ms,
  input wire logic o_torch_active_low,
  input wire logic o_torch_pulldown_en
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_arst_n);
  logic [10:0] base_ms;
  // timeout scaled back to the low torch figures
  assign base_ms = HIGH_TORCH ? (o_flash_timeout_ms >> 2)
                              : o_flash_timeout_ms;
  // ==========================================
  // sequences
  sequence s_swrst_pulse;
    o_soft_reset ##1 !o_soft_reset;
  endsequence
  sequence s_enabled_twice;
    (i_operating_mode_field != 2'b00) ##1 (i_operating_mode_field != 2'b00);
  endsequence
  // ==========================================
  // assertions
  a_reset_defaults: assert property (
    disable iff (1'b0) !i_arst_n |-> o_short_detect_en && o_ilim_high &&
      !o_pass_mode_only && !o_freq_4mhz && o_sda_oe_n)
    else $error("outputs not at defaults during reset");
  a_swrst_one_pulse: assert property (
    $rose(o_soft_reset) |-> s_swrst_pulse)
    else $error("soft reset pulse not one cycle");
  a_swrst_boost_dflt: assert property (
    o_soft_reset |-> o_short_detect_en && o_ilim_high && !o_pass_mode_only &&
      !o_freq_4mhz && !o_torch_active_low)
    else $error("soft reset left a setting off default");
  a_swrst_timing_dflt: assert property (
    o_soft_reset |=> base_ms == 11'h096 && o_torch_ramp_ms == 11'h001)
    else $error("soft reset left timing off default");
  a_timeout_legal: assert property (
    $past(i_arst_n) |->
    (base_ms >= 11'h00A && base_ms <= 11'h064 && base_ms % 10 == 0) ||
    (base_ms >= 11'h096 && base_ms <= 11'h190 && base_ms % 50 == 0))
    else $error("flash timeout not a legal duration");
  a_mode_enable: assert property (
    1'b1 |=> o_device_enabled == ($past(i_operating_mode_field) != 2'b00))
    else $error("enabled flag does not follow mode");
  a_polarity_frozen: assert property (
    s_enabled_twice |-> $stable(o_torch_active_low))
    else $error("torch polarity changed while enabled");
  a_pulldown_inverse: assert property (
    o_torch_pulldown_en == !o_torch_active_low)
    else $error("pulldown not inverse of polarity");
  c_soft_reset: cover property (o_soft_reset);
endmodule : fdr_regs_props

bind fdr_regs fdr_regs_props #(.HIGH_TORCH(HIGH_TORCH)) u_fdr_regs_props (
  .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .o_sda_oe_n(o_sda_oe_n),
  .i_operating_mode_field(i_operating_mode_field),
  .o_soft_reset(o_soft_reset), .o_device_enabled(o_device_enabled),
  .o_short_detect_en(o_short_detect_en), .o_pass_mode_only(o_pass_mode_only),
  .o_freq_4mhz(o_freq_4mhz), .o_ilim_high(o_ilim_high),
  .o_flash_timeout_ms(o_flash_timeout_ms), .o_torch_ramp_ms(o_torch_ramp_ms),
  .o_torch_active_low(o_torch_active_low),
  .o_torch_pulldown_en(o_torch_pulldown_en));

/* File: bench/fdr_host_model.sv */
// serial host model that reaches the register bank
`timescale 1ns/1ps
module fdr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h30
) (
  input wire logic i_ref_clk,
  input wire logic i_sda_wire,
  output logic o_scl,
  output logic o_sda
);
  // o_sda high means released, the pull-up then holds the wire high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : wt
  task automatic send_bit(input logic b);
    o_sda = b;
    wt(2);
    o_scl = 1'b1;
    wt(4);
    o_scl = 1'b0;
    wt(2);
  endtask : send_bit
  task automatic get_bit(output logic b);
    o_sda = 1'b1;
    wt(2);
    o_scl = 1'b1;
    wt(2);
    b = i_sda_wire;
    wt(2);
    o_scl = 1'b0;
    wt(2);
  endtask : get_bit
  task automatic start_cond();
    o_sda = 1'b1;
    wt(2);
    o_scl = 1'b1;
    wt(4);
    o_sda = 1'b0;
    wt(4);
    o_scl = 1'b0;
    wt(2);
  endtask : start_cond
  task automatic stop_cond();
    o_sda = 1'b0;
    wt(2);
    o_scl = 1'b1;
    wt(4);
    o_sda = 1'b1;
    wt(4);
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] d);
    logic ack;
    for (int i = 7; i >= 0; i--) send_bit(d[i]);
    get_bit(ack);
  endtask : put_byte
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ofs);
    put_byte(d);
    stop_cond();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    start_cond();
    put_byte({DEV_ADDR, 1'b0});
    put_byte(ofs);
    start_cond();
    put_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    send_bit(1'b1);
    stop_cond();
  endtask : read_reg
endmodule : fdr_host_model

/* File: bench/tb_fdr_regs.sv */
// self-checking bench for the flash driver register bank
`timescale 1ns/1ps
module tb_fdr_regs;
  import fdr_pkg::*;
  localparam logic [2:0] ID_VAL = 3'h6; // arbitrary identity value
  localparam logic [2:0] REV_VAL = 3'h3; // arbitrary identity value
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic scl, host_sda, sda_wire, dev_sda, oe_n, swrst, enabled;
  logic short_en, pass, f4, ilim, act_low, pd;
  logic t_open, t_short, t_func;
  logic [2:0] t_thr;
  logic [3:0] bst;
  logic [1:0] mode = 2'b00;
  logic [7:0] fp = 8'h00;
  logic [4:0] fs = 5'h00;
  logic cv = 1'b0;
  logic [6:0] code = 7'h00;
  logic [10:0] tmo, ramp;
  int num_errors = 0;
  int n_tests = 0;
  int swrst_cnt = 0;
  always #4 clk = ~clk;
  assign sda_wire = (oe_n === 1'b0) ? 1'b0 : host_sda;
  assign bst = {short_en, pass, f4, ilim};
  always @(posedge clk) if (swrst === 1'b1) swrst_cnt++;
  fdr_regs #(.PART_ID(ID_VAL), .SILICON_REV(REV_VAL)) u_fdr_regs (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(dev_sda), .o_sda_oe_n(oe_n), .i_operating_mode_field(mode),
    .i_fault_primary(fp), .i_fault_secondary(fs),
    .i_flash_monitor_valid(cv), .i_flash_monitor_code(code),
    .o_soft_reset(swrst), .o_device_enabled(enabled),
    .o_short_detect_en(short_en), .o_pass_mode_only(pass),
    .o_freq_4mhz(f4), .o_ilim_high(ilim), .o_flash_timeout_ms(tmo),
    .o_torch_ramp_ms(ramp), .o_torch_active_low(act_low),
    .o_torch_pulldown_en(pd), .o_thermistor_open_en(t_open),
    .o_thermistor_short_en(t_short), .o_temperature_threshold(t_thr),
    .o_torch_pin_function(t_func));
  fdr_host_model u_fdr_host_model (.i_ref_clk(clk), .i_sda_wire(sda_wire),
    .o_scl(scl), .o_sda(host_sda));
  // ==========================================
  // helpers
  task automatic stop_test();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask : check_reg
  task automatic check_out(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t output %h expected %h", $time, got, exp);
    end
  endtask : check_out
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    u_fdr_host_model.write_reg(ofs, d);
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    u_fdr_host_model.read_reg(ofs, d);
    check_reg(d, exp);
  endtask : rd
  task automatic pulse(input logic [7:0] p, input logic [4:0] s);
    @(negedge clk);
    fp = p;
    fs = s;
    @(negedge clk);
    fp = 8'h00;
    fs = 5'h00;
  endtask : pulse
  task automatic send_code(input logic [6:0] c);
    @(negedge clk);
    code = c;
    cv = 1'b1;
    @(negedge clk);
    cv = 1'b0;
  endtask : send_code
  function automatic logic [10:0] tmo_exp(input logic [3:0] c);
    return (c < 4'hA) ? 11'((c + 1) * 10) : 11'(150 + (c - 10) * 50);
  endfunction : tmo_exp
  function automatic logic [10:0] ramp_exp(input logic [2:0] r);
    return (r == 3'h0) ? 11'h000 : (r == 3'h1) ? 11'h001 : 11'h001 << (r + 3);
  endfunction : ramp_exp
  // ==========================================
  // scenarios
  task automatic t_defaults();
    rd(8'h07, 8'h09);
    rd(8'h08, 8'h1A);
    rd(8'h09, 8'h08);
    check_out(tmo, 11'h096);
    check_out({7'h00, short_en, pass, f4, ilim}, 11'h009);
  endtask : t_defaults
  task automatic t_boost();
    logic [7:0] p [3] = '{8'h76, 8'h01, 8'h0F};
    foreach (p[i]) begin
      wr(8'h07, p[i]);
      rd(8'h07, p[i] & 8'h0F);
      check_out(11'(bst), 11'(p[i][3:0]));
    end
  endtask : t_boost
  task automatic t_timing();
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      wr(8'h08, {1'b0, c[2:0], c});
      @(negedge clk);
      check_out(tmo, tmo_exp(c));
      check_out(ramp, ramp_exp(c[2:0]));
    end
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h7F);
  endtask : t_timing
  task automatic t_swrst();
    wr(8'h08, 8'h35);
    wr(8'h09, 8'h7E);
    check_out(11'({dev_sda, t_open, t_short, t_thr, t_func}), 11'h03E);
    swrst_cnt = 0;
    wr(8'h07, 8'h80);
    check_out(11'(swrst_cnt), 11'h001);
    rd(8'h07, 8'h09);
    rd(8'h08, 8'h1A);
    rd(8'h09, 8'h08);
    check_out(11'({dev_sda, t_open, t_short, t_thr, t_func}), 11'h008);
  endtask : t_swrst
  task automatic t_polarity();
    for (int m = 1; m < 4; m++) begin
      @(negedge clk);
      mode = 2'(m);
      wr(8'h09, 8'h48);
      rd(8'h09, 8'h08);
      check_out({10'h000, enabled}, 11'h001);
    end
    @(negedge clk);
    mode = 2'b00;
    wr(8'h09, 8'h40);
    rd(8'h09, 8'h40);
    check_out({9'h000, act_low, pd}, 11'h002);
    check_out({10'h000, enabled}, 11'h000);
    @(negedge clk);
    mode = 2'b10;
    wr(8'h09, 8'h00);
    rd(8'h09, 8'h40);
    @(negedge clk);
    mode = 2'b00;
  endtask : t_polarity
  task automatic t_flags();
    pulse(8'hA5, 5'h00);
    rd(8'h0A, 8'hA5);
    rd(8'h0A, 8'h00);
    wr(8'h07, 8'h01);
    pulse(8'h7A, 5'h1F);
    rd(8'h0A, 8'h0A);
    rd(8'h0B, 8'h07);
    wr(8'h09, 8'h30);
    pulse(8'h00, 5'h18);
    rd(8'h0B, 8'h18);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
  endtask : t_flags
  task automatic t_ident();
    send_code(7'h5A);
    send_code(7'h03);
    rd(8'h0D, 8'h03);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'h03);
    wr(8'h0C, 8'h00);
    rd(8'h0C, {2'b00, ID_VAL, REV_VAL});
  endtask : t_ident
  // ==========================================
  // main sequence and watchdog
  initial begin
    #1 arst_n = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    t_defaults();
    t_boost();
    t_timing();
    t_swrst();
    t_polarity();
    t_flags();
    t_ident();
    stop_test();
  end
  initial begin
    #400000;
    num_errors++;
    stop_test();
  end
endmodule : tb_fdr_regs
